// ===== exec_unit.sv
// Purpose: One-cycle execution of field extract/insert, increment, left
//          shift, complement-move, jump, jump-to-subroutine and escape trap.
// Assumes: Decoder presents one request per req_valid pulse with operands
//          fetched; effective address resolved by the operand stage.
// Notes:   All results appear registered one clock after the request.
//          Outputs fall back to zero a cycle later, so a stale write
//          is never applied twice.
`timescale 1ns/10ps
module exec_unit
  import exec_unit_pkg::*;
(
  input  wire logic       clk,       // Processor clock, 40 MHz
  input  wire logic       reset_n,   // Asynchronous reset, active low
  input  wire logic       req_valid, // One-cycle request strobe
  input  wire exec_req_t  req,       // Decoded opcode and operands
  output      logic       done,      // Request finished, one cycle
  output      dst_out_t   dst_out,   // Destination write and value
  output      flags_out_t flags_out, // Condition flag update
  output      flow_out_t  flow_out,  // PC load and stack push
  output      exc_out_t   exc_out    // Exception requests
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Value mask of an operand size
  function automatic logic [31:0] size_mask(input size_t size);
    unique case (size)
      SIZE_BYTE: size_mask = MASK_BYTE;
      SIZE_HALF: size_mask = MASK_HALF;
      SIZE_WORD: size_mask = MASK_WORD;
      default:   size_mask = MASK_WORD;
    endcase
  endfunction

  // Bit count of an operand size
  function automatic logic [5:0] size_bits(input size_t size);
    unique case (size)
      SIZE_BYTE: size_bits = BITS_BYTE;
      SIZE_HALF: size_bits = BITS_HALF;
      SIZE_WORD: size_bits = BITS_WORD;
      default:   size_bits = BITS_WORD;
    endcase
  endfunction

  // Sign bit of a value at an operand size
  function automatic logic sign_of(input logic [31:0] val,
                                   input size_t       size);
    unique case (size)
      SIZE_BYTE: sign_of = val[7];
      SIZE_HALF: sign_of = val[15];
      SIZE_WORD: sign_of = val[31];
      default:   sign_of = val[31];
    endcase
  endfunction

  // Run of width+1 ones from bit 0
  function automatic logic [31:0] ones_of(input logic [4:0] w);
    ones_of = MASK_WORD >> (5'd31 - w);
  endfunction

  // Rotate left within a word; a word insert wraps its field this way
  function automatic logic [31:0] rotate_left(input logic [31:0] val,
                                              input logic [4:0]  amt);
    logic [63:0] pair;
    pair        = {val, val} << amt;
    rotate_left = pair[63:32];
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  op_class_t   op;
  size_t       size;
  logic [4:0]  width5;
  logic [4:0]  offset5;
  logic [4:0]  count5;
  logic [5:0]  field_len;
  logic [6:0]  field_end;

  // Opcode to class and operand size
  always_comb begin
    op   = OP_NONE;
    size = SIZE_WORD;
    unique case (req.opcode)
      OPC_FIELD_EXTRACT_BYTE:   begin op = OP_EXTRACT; size = SIZE_BYTE; end
      OPC_FIELD_EXTRACT_HALF:   begin op = OP_EXTRACT; size = SIZE_HALF; end
      OPC_FIELD_EXTRACT_WORD:   begin op = OP_EXTRACT; size = SIZE_WORD; end
      OPC_FIELD_INSERT_BYTE:    begin op = OP_INSERT; size = SIZE_BYTE; end
      OPC_FIELD_INSERT_HALF:    begin op = OP_INSERT; size = SIZE_HALF; end
      OPC_FIELD_INSERT_WORD:    begin op = OP_INSERT; size = SIZE_WORD; end
      OPC_INCREMENT_BYTE:       begin op = OP_INCREMENT; size = SIZE_BYTE; end
      OPC_INCREMENT_HALF:       begin op = OP_INCREMENT; size = SIZE_HALF; end
      OPC_INCREMENT_WORD:       begin op = OP_INCREMENT; size = SIZE_WORD; end
      OPC_LEFT_SHIFT_BYTE:      begin op = OP_SHIFT; size = SIZE_BYTE; end
      OPC_LEFT_SHIFT_HALF:      begin op = OP_SHIFT; size = SIZE_HALF; end
      OPC_LEFT_SHIFT_WORD:      begin op = OP_SHIFT; size = SIZE_WORD; end
      OPC_COMPLEMENT_MOVE_BYTE: begin op = OP_COMPLEMENT; size = SIZE_BYTE; end
      OPC_COMPLEMENT_MOVE_HALF: begin op = OP_COMPLEMENT; size = SIZE_HALF; end
      OPC_COMPLEMENT_MOVE_WORD: begin op = OP_COMPLEMENT; size = SIZE_WORD; end
      OPC_JUMP_TO_ADDRESS:      op = OP_JUMP;
      OPC_JUMP_SUBROUTINE:      op = OP_SUBROUTINE;
      OPC_ESCAPE_TRAP_OPCODE:   op = OP_ESCAPE;
      // Unknown opcodes give only the done pulse
      default:                  op = OP_NONE;
    endcase
  end

  assign width5    = req.width[SEL_BITS-1:0];
  assign offset5   = req.offset[SEL_BITS-1:0];
  assign count5    = req.count[SEL_BITS-1:0];
  // Field end is one past its top bit; seven bits hold the largest sum
  assign field_len = {1'b0, width5} + 6'h01;
  assign field_end = {2'b00, width5} + {2'b00, offset5} + 7'h01;

  // ****************************************************************
  // Datapath
  // ****************************************************************
  logic [31:0] mask;
  logic [31:0] fmask;
  logic [63:0] src_pair;
  logic [63:0] mask_wide;
  logic [63:0] data_wide;
  logic [31:0] ins_mask;
  logic [31:0] ins_data;
  logic [31:0] dst_sized;
  logic [31:0] inverse;
  logic [32:0] inc_sum;
  logic        dst_bad;
  logic        jump_bad;
  logic [31:0] next_value;
  logic        next_write;
  cond_flags_t next_flags;
  logic        next_flags_write;
  logic        next_illegal;
  logic        next_overflow_exc;

  assign mask      = size_mask(size);
  assign fmask     = ones_of(width5);
  assign dst_sized = req.dst & mask;
  assign inverse   = ~req.src;
  assign inc_sum   = {1'b0, dst_sized} + 33'h0_0000_0001;
  // doubled source makes the field wrap
  assign src_pair  = {req.src, req.src} >> offset5;
  assign mask_wide = {32'h0000_0000, fmask} << offset5;
  assign data_wide = {32'h0000_0000, req.src & fmask} << offset5;

  // Insert mask: rotated for word, plain shift clipped for byte/half
  always_comb begin
    if (size == SIZE_WORD) begin
      // bits past bit 31 come round to bit 0
      ins_mask = rotate_left(fmask, offset5);
      ins_data = rotate_left(req.src & fmask, offset5);
    end else begin
      // nothing outside destination size is touched
      ins_mask = mask_wide[31:0] & mask;
      ins_data = data_wide[31:0] & mask;
    end
  end

  // literal or immediate destination is illegal
  assign dst_bad  = (req.dst_mode == MODE_LITERAL) ||
                    (req.dst_mode == MODE_IMMEDIATE);
  // jumps need a memory effective address
  // Expanded type is refused only by the subroutine call, below
  assign jump_bad = dst_bad || (req.dst_mode == MODE_REGISTER);

  // Result, flags and exceptions of the data instructions
  always_comb begin
    next_value        = RESET_WORD;
    next_write        = 1'b0;
    next_flags        = '0;
    next_flags_write  = 1'b0;
    next_illegal      = 1'b0;
    next_overflow_exc = 1'b0;
    unique case (op)
      OP_EXTRACT: begin
        next_value   = src_pair[31:0] & fmask & mask;
        next_flags.v = field_len > size_bits(size);
      end
      OP_INSERT: begin
        next_value   = (dst_sized & ~ins_mask) | ins_data;
        // overrun of byte or half sets V
        next_flags.v = (size != SIZE_WORD) &&
                       (field_end > {1'b0, size_bits(size)});
      end
      OP_INCREMENT: begin
        next_value   = inc_sum[31:0] & mask;
        // carry out of sign, overflow traps
        // C means the operand was all ones; V means max positive went
        // to most negative, the only signed overflow a +1 can make
        next_flags.c = (dst_sized == mask);
        next_flags.v = sign_of(next_value, size) & ~sign_of(req.dst, size);
      end
      OP_SHIFT: begin
        // zeros shifted in at bit 0
        next_value = (req.src << count5) & mask;
      end
      OP_COMPLEMENT: begin
        next_value   = inverse & mask;
        // dropped bits not a sign extension
        // Source arrives expanded to 32 bits; its upper bits must mirror
        // the size MSB, otherwise the value did not fit
        next_flags.v = (inverse & ~mask) !=
                       (sign_of(inverse, size) ? ~mask : RESET_WORD);
      end
      default: next_value = RESET_WORD;
    endcase
    if (op inside {OP_EXTRACT, OP_INSERT, OP_INCREMENT, OP_SHIFT,
                   OP_COMPLEMENT}) begin
      if (dst_bad) begin
        next_illegal = 1'b1;
        next_flags   = '0;
      end else begin
        // N from MSB, Z on zero, C clear except for increment
        next_write       = 1'b1;
        next_flags_write = 1'b1;
        next_flags.n     = sign_of(next_value, size);
        next_flags.z     = (next_value == RESET_WORD);
        if (op != OP_INCREMENT) begin
          next_flags.c = 1'b0;
        end
        next_overflow_exc = (op == OP_INCREMENT) && next_flags.v;
      end
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Pulses rather than levels: the decoder has no handshake, so each
  // result is offered for exactly one clock.

  // Completion strobe
  // Unknown opcodes still pulse it, so the decoder never stalls
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
    end else begin
      done <= req_valid;
    end
  end

  // Destination write-back
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dst_out <= '0;
    end else begin
      dst_out.write <= req_valid && next_write;
      dst_out.value <= req_valid ? next_value : RESET_WORD;
    end
  end

  // Condition flags; jumps and escape never touch them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_out <= '0;
    end else begin
      flags_out.write <= req_valid && next_flags_write;
      flags_out.flags <= req_valid ? next_flags : '0;
    end
  end

  // Program counter and stack, only for legal jump operands
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flow_out <= '0;
    end else begin
      // Cleared each cycle so every field is a one-cycle pulse
      flow_out <= '0;
      if (req_valid && op == OP_JUMP && !jump_bad) begin
        flow_out.pc_load  <= 1'b1;
        flow_out.pc_value <= req.eff_addr;
      end
      // push next address, post-increment SP, then jump
      if (req_valid && op == OP_SUBROUTINE && !jump_bad &&
          req.dst_mode != MODE_EXPANDED) begin
        flow_out.push      <= 1'b1;
        flow_out.push_addr <= req.sp;
        flow_out.push_data <= req.next_pc;
        flow_out.sp_write  <= 1'b1;
        flow_out.sp_value  <= req.sp + STACK_STEP;
        flow_out.pc_load   <= 1'b1;
        flow_out.pc_value  <= req.eff_addr;
      end
    end
  end

  // Exception requests
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      exc_out <= '0;
    end else begin
      // trap right after decode, trailing byte unused
      // Escape never reads req.src, where its trailing byte would sit
      exc_out.reserved_opcode <= req_valid && op == OP_ESCAPE;
      exc_out.illegal_operand <= req_valid && (next_illegal ||
        (op == OP_JUMP && jump_bad) ||
        (op == OP_SUBROUTINE &&
         (jump_bad || req.dst_mode == MODE_EXPANDED)));
      exc_out.int_overflow    <= req_valid && next_overflow_exc;
    end
  end

endmodule // exec_unit

// ===== exec_unit_pkg.sv
// Purpose: Shared opcodes, operand modes and carrier types for the
//          bit-field, shift, increment and jump execution group.
// Assumes: Operands arrive already fetched and zero/sign expanded to 32 bits.
// Notes:   Opcode values are the instruction encodings, not local choices.
package exec_unit_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_FIELD_EXTRACT_BYTE    = 8'hCF;
  localparam logic [7:0] OPC_FIELD_EXTRACT_HALF    = 8'hCE;
  localparam logic [7:0] OPC_FIELD_EXTRACT_WORD    = 8'hCC;
  localparam logic [7:0] OPC_ESCAPE_TRAP_OPCODE    = 8'h14;
  localparam logic [7:0] OPC_INCREMENT_BYTE        = 8'h93;
  localparam logic [7:0] OPC_INCREMENT_HALF        = 8'h92;
  localparam logic [7:0] OPC_INCREMENT_WORD        = 8'h90;
  localparam logic [7:0] OPC_FIELD_INSERT_BYTE     = 8'hCB;
  localparam logic [7:0] OPC_FIELD_INSERT_HALF     = 8'hCA;
  localparam logic [7:0] OPC_FIELD_INSERT_WORD     = 8'hC8;
  localparam logic [7:0] OPC_JUMP_TO_ADDRESS       = 8'h24;
  localparam logic [7:0] OPC_JUMP_SUBROUTINE       = 8'h34;
  localparam logic [7:0] OPC_LEFT_SHIFT_BYTE       = 8'hD3;
  localparam logic [7:0] OPC_LEFT_SHIFT_HALF       = 8'hD2;
  localparam logic [7:0] OPC_LEFT_SHIFT_WORD       = 8'hD0;
  localparam logic [7:0] OPC_COMPLEMENT_MOVE_BYTE  = 8'h8B;
  localparam logic [7:0] OPC_COMPLEMENT_MOVE_HALF  = 8'h8A;
  localparam logic [7:0] OPC_COMPLEMENT_MOVE_WORD  = 8'h88;

  // ****************************************************************
  // Widths, positions and reset values
  // ****************************************************************
  localparam logic [5:0]  BITS_BYTE   = 6'h08;
  localparam logic [5:0]  BITS_HALF   = 6'h10;
  localparam logic [5:0]  BITS_WORD   = 6'h20;
  localparam logic [31:0] MASK_BYTE   = 32'h0000_00FF;
  localparam logic [31:0] MASK_HALF   = 32'h0000_FFFF;
  localparam logic [31:0] MASK_WORD   = 32'hFFFF_FFFF;
  localparam logic [31:0] STACK_STEP  = 32'h0000_0004;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam int          SEL_BITS    = 5;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_MEMORY, MODE_REGISTER, MODE_LITERAL, MODE_IMMEDIATE, MODE_EXPANDED
  } mode_t;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} size_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_EXTRACT, OP_INSERT, OP_INCREMENT, OP_SHIFT,
    OP_COMPLEMENT, OP_JUMP, OP_SUBROUTINE, OP_ESCAPE
  } op_class_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } cond_flags_t;

  typedef struct packed {
    logic [7:0]  opcode;
    mode_t       dst_mode;
    logic [31:0] width;
    logic [31:0] offset;
    logic [31:0] count;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] eff_addr;
    logic [31:0] next_pc;
    logic [31:0] sp;
  } exec_req_t;

  typedef struct packed {
    logic        write;
    logic [31:0] value;
  } dst_out_t;

  typedef struct packed {
    logic        write;
    cond_flags_t flags;
  } flags_out_t;

  typedef struct packed {
    logic        pc_load;
    logic [31:0] pc_value;
    logic        push;
    logic [31:0] push_addr;
    logic [31:0] push_data;
    logic        sp_write;
    logic [31:0] sp_value;
  } flow_out_t;

  typedef struct packed {
    logic reserved_opcode;
    logic illegal_operand;
    logic int_overflow;
  } exc_out_t;

endpackage

// ===== exec_unit_props.sv
// Purpose: Port-level checks on exec_unit.
// Assumes: One clock domain, results one cycle after req_valid.
// Notes:   Watches design ports only, the request inputs as well as the outputs.
`timescale 1ns/10ps
module exec_unit_props
  import exec_unit_pkg::*;
(
  input wire logic       clk,       // Clock
  input wire logic       reset_n,   // Reset, active low
  input wire logic       req_valid, // Request strobe
  input wire exec_req_t  req,       // Request
  input wire logic       done,      // Finished pulse
  input wire dst_out_t   dst_out,   // Destination write
  input wire flags_out_t flags_out, // Flag update
  input wire flow_out_t  flow_out,  // PC and stack
  input wire exc_out_t   exc_out    // Exceptions
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Short names for the request fields
  logic [7:0] op;
  mode_t      md;
  logic [4:0] cnt5;
  assign op   = req_valid ? req.opcode : 8'h00;
  assign md   = req.dst_mode;
  assign cnt5 = req.count[4:0];

  property p_escape;
    op == 8'h14 |=> exc_out.reserved_opcode && !flags_out.write
      && !dst_out.write;
  endproperty
  a_escape: assert property (p_escape) else $error("escape bad");
  property p_jump;
    op == 8'h24 && md == MODE_MEMORY |=> flow_out.pc_load
      && flow_out.pc_value == $past(req.eff_addr) && !flags_out.write;
  endproperty
  a_jump: assert property (p_jump) else $error("jump bad");
  property p_sub;
    op == 8'h34 && md == MODE_MEMORY |=> flow_out.push
      && flow_out.push_addr == $past(req.sp)
      && flow_out.push_data == $past(req.next_pc)
      && flow_out.sp_value == $past(req.sp) + 32'h4;
  endproperty
  a_sub: assert property (p_sub) else $error("call bad");
  property p_sub_bad;
    op == 8'h34 && md inside {MODE_LITERAL, MODE_EXPANDED, MODE_IMMEDIATE}
      |=> exc_out.illegal_operand && !flow_out.push && !flow_out.pc_load;
  endproperty
  a_sub_bad: assert property (p_sub_bad) else $error("call mode");
  property p_jump_bad;
    op == 8'h24 && md inside {MODE_LITERAL, MODE_REGISTER, MODE_IMMEDIATE}
      |=> exc_out.illegal_operand && !flow_out.pc_load;
  endproperty
  a_jump_bad: assert property (p_jump_bad) else $error("jump mode");
  property p_illegal;
    op inside {8'hCC, 8'hCB, 8'h93, 8'hD0, 8'h88}
      && md inside {MODE_LITERAL, MODE_IMMEDIATE}
      |=> exc_out.illegal_operand && !dst_out.write && !flags_out.write;
  endproperty
  a_illegal: assert property (p_illegal) else $error("no trap");
  property p_inc;
    op == 8'h90 && md == MODE_REGISTER
      |=> dst_out.value == $past(req.dst) + 32'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("inc bad");
  property p_shift;
    op == 8'hD0 && md == MODE_REGISTER
      |=> dst_out.value == $past(req.src) << $past(cnt5);
  endproperty
  a_shift: assert property (p_shift) else $error("shift bad");
  property p_ovf;
    exc_out.int_overflow |-> flags_out.write && flags_out.flags.v;
  endproperty
  a_ovf: assert property (p_ovf) else $error("ovf no V");
endmodule // exec_unit_props

// ===== decode_feeder.sv
// Purpose: Decode and operand stage model feeding exec_unit.
// Assumes: Bench raises fire for one cycle per instruction.
// Notes:   Idle request lines show an inverted pattern.
`timescale 1ns/10ps
module decode_feeder
  import exec_unit_pkg::*;
(
  input  wire logic      clk,       // Clock
  input  wire logic      reset_n,   // Reset, active low
  input  wire logic      fire,      // Issue one request
  input  wire exec_req_t item,      // Request to issue
  output      logic      req_valid, // Request strobe
  output      exec_req_t req        // Request contents
);
  // Launch on the edge; idle data toggles so stale values never match
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else begin
      req_valid <= fire;
      req       <= fire ? item : exec_req_t'(~req);
    end
  end
endmodule // decode_feeder

// ===== exec_unit_tb.sv
// Purpose: Self-checking bench for exec_unit.
// Assumes: One request at a time, results one clock later.
// Notes:   Expected values worked out by hand.
`timescale 1ns/10ps
module exec_unit_tb;
  import exec_unit_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       fire = 1'b0;
  exec_req_t  item = '0;
  logic       req_valid;
  exec_req_t  req;
  logic       done;
  dst_out_t   dst_out;
  flags_out_t flags_out;
  flow_out_t  flow_out;
  exc_out_t   exc_out;
  int         fail_count = 0;
  int         checks = 0;

  always #12.5 clk = ~clk;

  decode_feeder feed (.clk(clk), .reset_n(reset_n), .fire(fire),
    .item(item), .req_valid(req_valid), .req(req));
  exec_unit dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .done(done), .dst_out(dst_out), .flags_out(flags_out),
    .flow_out(flow_out), .exc_out(exc_out));

  // ****
  // Helpers
  // ****
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Issue one request, wait for the answer, which stands one cycle
  task automatic run(logic [7:0] op, mode_t m, logic [31:0] a, b, s, d);
    item = '{op, m, a, b, a, s, d, 32'h4000, 32'h1008, 32'h2000};
    fire = 1'b1;
    @(posedge clk);
    #2 fire = 1'b0;
    @(posedge clk);
    #2 chk("done", 32'h1, {31'h0, done});
  endtask
  task automatic data(logic [31:0] v, logic [3:0] f);
    chk("value", v, dst_out.value);
    chk("wr_nzcv", {26'h0, 2'h3, f},
      {26'h0, dst_out.write, flags_out.write, flags_out.flags});
  endtask
  // Exception bits, pc load, then both writes, which must stay low
  task automatic trap(logic [2:0] e, logic pc);
    chk("exc", {26'h0, e, pc, 2'h0}, {26'h0, exc_out, flow_out.pc_load,
      dst_out.write, flags_out.write});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_data();
    run(8'hCC, MODE_REGISTER, 32'hA, 32'h4, 32'h0123_4567, 32'h0);
    data(32'h456, 4'h0);
    run(8'hCC, MODE_MEMORY, 32'hFFFF_FFE7, 32'h3C, 32'hF000_000A, 32'h0);
    data(32'hAF, 4'h0);
    run(8'hCF, MODE_REGISTER, 32'hB, 32'h4, 32'h0123_4567, 32'h0);
    data(32'h56, 4'h1);
    run(8'hCE, MODE_REGISTER, 32'h3, 32'h0, 32'h5, 32'h0);
    data(32'h5, 4'h0);
    run(8'hC8, MODE_REGISTER, 32'hFFFF_FFEB, 32'h8, 32'h567, 32'hABCD_EF01);
    data(32'hABC5_6701, 4'h8);
    run(8'hC8, MODE_REGISTER, 32'h7, 32'h1C, 32'hFFFF_FFAF, 32'h0);
    data(32'hF000_000A, 4'h8);
    run(8'hCB, MODE_REGISTER, 32'h7, 32'h4, 32'hFF, 32'h0);
    data(32'hF0, 4'h9);
    run(8'hCA, MODE_REGISTER, 32'h3, 32'hC, 32'hF, 32'h0);
    data(32'hF000, 4'h8);
    run(8'hD3, MODE_REGISTER, 32'h22, 32'h0, 32'hF, 32'h0);
    data(32'h3C, 4'h0);
    run(8'hD2, MODE_REGISTER, 32'h2, 32'h0, 32'h0F0F_DFFD, 32'h0);
    data(32'h7FF4, 4'h0);
    run(8'hD0, MODE_REGISTER, 32'h1F, 32'h0, 32'h1, 32'h0);
    data(32'h8000_0000, 4'h8);
    run(8'h88, MODE_REGISTER, 32'h0, 32'h0, 32'h1234_5678, 32'h0);
    data(32'hEDCB_A987, 4'h8);
    run(8'h8B, MODE_REGISTER, 32'h0, 32'h0, 32'hFF, 32'h0);
    data(32'h0, 4'h5);
    run(8'h8A, MODE_REGISTER, 32'h0, 32'h0, 32'hFFFF_8000, 32'h0);
    data(32'h7FFF, 4'h0);
    $display("data ops finished");
  endtask
  task automatic t_inc();
    run(8'h93, MODE_REGISTER, 32'h0, 32'h0, 32'h0, 32'h7F);
    data(32'h80, 4'h9);
    chk("ovf_exc", 32'h1, {29'h0, exc_out});
    run(8'h93, MODE_REGISTER, 32'h0, 32'h0, 32'h0, 32'hFF);
    data(32'h0, 4'h6);
    run(8'h92, MODE_REGISTER, 32'h0, 32'h0, 32'h0, 32'h1234);
    data(32'h1235, 4'h0);
    run(8'h90, MODE_REGISTER, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF);
    data(32'h0, 4'h6);
    $display("increment finished");
  endtask
  task automatic t_flow();
    mode_t jm[3];
    mode_t sm[3];
    jm = '{MODE_LITERAL, MODE_REGISTER, MODE_IMMEDIATE};
    sm = '{MODE_LITERAL, MODE_EXPANDED, MODE_IMMEDIATE};
    run(8'h14, MODE_MEMORY, 32'h0, 32'h0, 32'h2F, 32'h0);
    trap(3'b100, 1'b0);
    run(8'h24, MODE_MEMORY, 32'h0, 32'h0, 32'h0, 32'h0);
    trap(3'b000, 1'b1);
    chk("pc", 32'h4000, flow_out.pc_value);
    run(8'h34, MODE_MEMORY, 32'h0, 32'h0, 32'h0, 32'h0);
    trap(3'b000, 1'b1);
    chk("push_addr", 32'h2000, flow_out.push_addr);
    chk("push_data", 32'h1008, flow_out.push_data);
    chk("sp", 32'h2004, flow_out.sp_value);
    chk("pc", 32'h4000, flow_out.pc_value);
    chk("ctl", 32'h7, {29'h0, flow_out.push, flow_out.sp_write,
      flow_out.pc_load});
    for (int i = 0; i < 3; i++) begin
      run(8'h24, jm[i], 32'h0, 32'h0, 32'h0, 32'h0);
      trap(3'b010, 1'b0);
      run(8'h34, sm[i], 32'h0, 32'h0, 32'h0, 32'h0);
      trap(3'b010, 1'b0);
    end
    $display("flow finished");
  endtask
  task automatic t_illegal();
    logic [7:0] ops[5];
    ops = '{8'hCC, 8'hCB, 8'h93, 8'hD0, 8'h88};
    for (int i = 0; i < 10; i++) begin
      run(ops[i/2], (i % 2) ? MODE_IMMEDIATE : MODE_LITERAL, 32'h3, 32'h1,
        32'h5, 32'h7);
      trap(3'b010, 1'b0);
    end
    $display("illegal modes finished");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence after a three cycle reset
  initial begin
    repeat (3) @(posedge clk);
    #2 reset_n = 1'b1;
    @(posedge clk);
    #2;
    t_data();
    t_inc();
    t_flow();
    t_illegal();
    close_out();
  end
  // Watchdog well past the roughly 80 cycles the tests need
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule // exec_unit_tb

bind exec_unit exec_unit_props props (.clk(clk), .reset_n(reset_n),
  .req_valid(req_valid), .req(req), .done(done), .dst_out(dst_out),
  .flags_out(flags_out), .flow_out(flow_out), .exc_out(exc_out));
